// ---- hw/cmd_decoder_regs.vh ----
// constants for the two-cycle command decoder: encodings, op and pending codes, sizes
// assumes the includer samples the command bus on clk_sys rising edges
`ifndef CMD_DECODER_REGS_VH
`define CMD_DECODER_REGS_VH

// first-cycle CA[4:0] codes (CA5 is a field)
`define ENC_MPC 5'h00
`define ENC_PRE 5'h10
`define ENC_REF 5'h08
`define ENC_SRE 5'h18
`define ENC_WR1 5'h04
`define ENC_SRX 5'h14
`define ENC_MWR1 5'h0C
`define ENC_RD1 5'h02
`define ENC_CAS2 5'h12
`define ENC_MRW1 5'h06
`define ENC_MRW2 5'h16
`define ENC_MRR1 5'h0E

// operation codes on op_code
`define OPC_NONE 4'h0
`define OPC_PRE 4'h1
`define OPC_REF 4'h2
`define OPC_SRE 4'h3
`define OPC_SRX 4'h4
`define OPC_WR 4'h5
`define OPC_MWR 4'h6
`define OPC_RD 4'h7
`define OPC_MRR 4'h8
`define OPC_MRW 4'h9
`define OPC_ACT 4'hA
`define OPC_MPC 4'hB

// pending first-half kinds
`define PEND_NONE 3'h0
`define PEND_CAS 3'h1
`define PEND_ACT 3'h2
`define PEND_MRW 3'h3
`define PEND_DES 3'h4

`define BURST_SHORT 6'h10
`define BURST_LONG 6'h20
// operands 0x40..0x7f of mpc that pair with CAS-2 (fifo / dq calibration)
`define MPC_CAS_MASK 7'h40
`define MPC_QUIET_DESELECTS 2'h2

`endif

// ---- hw/first_half_capture.v ----
// holds the first-cycle ca bits of a two-cycle command: kind code and CA5 flag
// assumes load_first is raised only on a selected first cycle
`timescale 1ns/100ps
`default_nettype none
module first_half_capture (
    input wire clk_sys,
    input wire rstn,
    input wire load_first,
    input wire [5:0] ca_in,
    output reg [5:0] first_ca_r
);
    // ----------------------------------------
    // first-cycle hold
    // ----------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            first_ca_r <= 6'h00;
        end else if (load_first) begin
            first_ca_r <= ca_in;
        end
    end
endmodule // first_half_capture
`default_nettype wire

// ---- hw/bank_mask_gen.v ----
// turns a bank number plus all-bank bit into a target mask: one-hot, or all ones when the all-bank bit is set
// assumes combinational use by the command decoder
`timescale 1ns/100ps
`default_nettype none
module bank_mask_gen #(
    parameter NUM_BANKS = 8
) (
    input wire [2:0] bank,
    input wire all_bank,
    output wire [NUM_BANKS-1:0] mask
);
    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g = g + 1) begin : g_bank
            assign mask[g] = all_bank | (bank == g);
        end
    endgenerate
endmodule // bank_mask_gen
`default_nettype wire

// ---- hw/cmd_decoder.v ----
// two-cycle command decoder for one channel of a low-power dram
// assumes cs and ca are synchronous to clk_sys, one sample per rising edge
`timescale 1ns/100ps
`default_nettype none
`include "cmd_decoder_regs.vh"
module cmd_decoder #(
    parameter NUM_BANKS = 8
) (
    input wire clk_sys,
    input wire rstn,
    input wire cs,
    input wire [5:0] ca,
    input wire otf_enable,
    input wire default_burst_long,
    input wire reinit_done,
    output reg op_valid_r,
    output reg [3:0] op_code_r,
    output reg [2:0] bank_r,
    output reg [NUM_BANKS-1:0] bank_mask_r,
    output reg all_bank_select_r,
    output reg auto_precharge_flag_r,
    output reg [5:0] burst_len_r,
    output reg [9:0] column_r,
    output reg [15:0] row_r,
    output reg [5:0] mode_addr_r,
    output reg [7:0] operand_r,
    output reg illegal_r
);
    // ----------------------------------------
    // phase state
    // ----------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_SECOND = 2'd1;
    localparam ST_AWAIT_CAS = 2'd2;
    localparam ST_AWAIT_PAIR = 2'd3;

    reg [1:0] state_r, state_nxt;
    reg [2:0] pend_r, pend_nxt;
    reg [1:0] quiet_r, quiet_nxt;
    reg [3:0] held_op_r, held_op_nxt;
    reg [2:0] held_bank_r, held_bank_nxt;
    reg held_autopre_r, held_autopre_nxt;
    reg held_c9_r, held_c9_nxt;
    reg held_burst_sel_r, held_burst_sel_nxt;
    reg [5:0] held_hi_r, held_hi_nxt;
    reg bad;
    reg fire;
    wire [5:0] first_ca;
    wire [NUM_BANKS-1:0] mask_w;
    wire load_first = (state_r != ST_SECOND) & cs;
    wire [4:0] enc = first_ca[4:0];

    // first-cycle fields feed the launch; the second cycle is read live on ca
    first_half_capture u_cap (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .load_first(load_first),
        .ca_in(ca),
        .first_ca_r(first_ca)
    );

    // bank bits are ignored by the mask whenever the all-bank bit is set
    bank_mask_gen #(.NUM_BANKS(NUM_BANKS)) u_mask (
        .bank(ca[2:0]),
        .all_bank(first_ca[5]),
        .mask(mask_w)
    );

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // activate halves are the only codes with CA0 high
    function is_act;
        input [4:0] e;
        begin
            is_act = e[0];
        end
    endfunction

    // ----------------------------------------
    // second-cycle decode and pairing checks
    // ----------------------------------------
    always @* begin
        state_nxt = state_r;
        pend_nxt = pend_r;
        quiet_nxt = quiet_r;
        held_op_nxt = held_op_r;
        held_bank_nxt = held_bank_r;
        held_autopre_nxt = held_autopre_r;
        held_c9_nxt = held_c9_r;
        held_burst_sel_nxt = held_burst_sel_r;
        held_hi_nxt = held_hi_r;
        bad = 1'b0;
        fire = 1'b0;
        case (state_r)
            ST_IDLE, ST_AWAIT_CAS, ST_AWAIT_PAIR: begin
                if (cs) begin
                    state_nxt = ST_SECOND;
                    if (pend_r == `PEND_DES && quiet_r != 2'd0) begin
                        bad = 1'b1;
                    end
                    if (state_r == ST_AWAIT_CAS && !(ca[4:0] == `ENC_CAS2)) begin
                        bad = 1'b1;
                    end
                    if (state_r == ST_AWAIT_PAIR) begin
                        if (pend_r == `PEND_ACT && !(ca[0] && ca[1])) begin
                            bad = 1'b1;
                        end
                        if (pend_r == `PEND_MRW && ca[4:0] != `ENC_MRW2) begin
                            bad = 1'b1;
                        end
                    end
                    if (state_r == ST_IDLE && (ca[4:0] == `ENC_CAS2 || ca[4:0] == `ENC_MRW2
                        || (ca[1:0] == 2'b11))) begin
                        bad = 1'b1; // second half without a first
                    end
                    if (ca[4:0] == `ENC_MWR1 && ca[5]) begin
                        bad = 1'b1;
                    end
                end else begin
                    // deselect: one cycle, nothing launched
                    // a deselect inside a pending pair breaks it; no way to resume
                    if (state_r != ST_IDLE) begin
                        bad = 1'b1;
                        state_nxt = ST_IDLE;
                        pend_nxt = `PEND_NONE;
                    end
                    if (pend_r == `PEND_DES) begin
                        if (quiet_r == 2'd1) begin
                            pend_nxt = `PEND_NONE;
                        end
                        quiet_nxt = quiet_r - 2'd1;
                    end
                end
            end
            ST_SECOND: begin
                state_nxt = ST_IDLE;
                if (pend_r != `PEND_DES) begin
                    pend_nxt = `PEND_NONE;
                end
                if (is_act(enc) && !enc[1]) begin
                    held_bank_nxt = ca[2:0];
                    held_hi_nxt = {2'b00, first_ca[5:2]};
                    held_c9_nxt = ca[4];
                    held_autopre_nxt = ca[5];
                    state_nxt = ST_AWAIT_PAIR;
                    pend_nxt = `PEND_ACT;
                end else if (is_act(enc)) begin
                    fire = 1'b1;
                end else begin
                    case (enc)
                        `ENC_WR1, `ENC_MWR1, `ENC_RD1, `ENC_MRR1: begin
                            held_op_nxt = (enc == `ENC_WR1) ? `OPC_WR :
                                (enc == `ENC_MWR1) ? `OPC_MWR :
                                (enc == `ENC_RD1) ? `OPC_RD : `OPC_MRR;
                            held_bank_nxt = ca[2:0];
                            held_c9_nxt = ca[4];
                            held_autopre_nxt = ca[5];
                            held_burst_sel_nxt = first_ca[5];
                            held_hi_nxt = ca;
                            state_nxt = ST_AWAIT_CAS;
                            pend_nxt = `PEND_CAS;
                        end
                        `ENC_MRW1: begin
                            held_hi_nxt = ca;
                            held_burst_sel_nxt = first_ca[5];
                            state_nxt = ST_AWAIT_PAIR;
                            pend_nxt = `PEND_MRW;
                        end
                        `ENC_MPC: begin
                            if (first_ca[5]) begin
                                held_op_nxt = `OPC_MPC;
                                held_hi_nxt = ca;
                                state_nxt = ST_AWAIT_CAS;
                                pend_nxt = `PEND_CAS;
                            end else begin
                                fire = 1'b1;
                                // two quiet cycles counted down before the next command
                                pend_nxt = `PEND_DES;
                                quiet_nxt = `MPC_QUIET_DESELECTS;
                            end
                        end
                        `ENC_CAS2, `ENC_MRW2, `ENC_PRE, `ENC_REF, `ENC_SRE, `ENC_SRX: begin
                            fire = 1'b1;
                        end
                        default: begin
                            bad = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // state and sticky illegal flag
    // ----------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            pend_r <= `PEND_NONE;
            quiet_r <= 2'd0;
            held_op_r <= `OPC_NONE;
            held_bank_r <= 3'd0;
            held_autopre_r <= 1'b0;
            held_c9_r <= 1'b0;
            held_burst_sel_r <= 1'b0;
            held_hi_r <= 6'h00;
            illegal_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pend_r <= pend_nxt;
            quiet_r <= quiet_nxt;
            held_op_r <= held_op_nxt;
            held_bank_r <= held_bank_nxt;
            held_autopre_r <= held_autopre_nxt;
            held_c9_r <= held_c9_nxt;
            held_burst_sel_r <= held_burst_sel_nxt;
            held_hi_r <= held_hi_nxt;
            // set wins over the re-initialisation clear
            if (bad) begin
                illegal_r <= 1'b1;
            end else if (reinit_done) begin
                illegal_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // operation outputs, one-cycle strobe
    // ----------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            op_valid_r <= 1'b0;
            op_code_r <= `OPC_NONE;
            bank_r <= 3'd0;
            bank_mask_r <= {NUM_BANKS{1'b0}};
            all_bank_select_r <= 1'b0;
            auto_precharge_flag_r <= 1'b0;
            burst_len_r <= `BURST_SHORT;
            column_r <= 10'h000;
            row_r <= 16'h0000;
            mode_addr_r <= 6'h00;
            operand_r <= 8'h00;
        end else begin
            op_valid_r <= fire & ~bad & ~illegal_r;
            if (fire) begin
                all_bank_select_r <= 1'b0;
                auto_precharge_flag_r <= 1'b0;
                case (enc)
                    `ENC_PRE, `ENC_REF: begin
                        op_code_r <= (enc == `ENC_PRE) ? `OPC_PRE : `OPC_REF;
                        bank_r <= ca[2:0];
                        all_bank_select_r <= first_ca[5];
                        bank_mask_r <= mask_w;
                    end
                    `ENC_SRE: op_code_r <= `OPC_SRE;
                    `ENC_SRX: op_code_r <= `OPC_SRX;
                    `ENC_MPC: begin
                        op_code_r <= `OPC_MPC;
                        operand_r <= {1'b0, first_ca[5], ca};
                    end
                    `ENC_MRW2: begin
                        op_code_r <= `OPC_MRW;
                        mode_addr_r <= held_hi_r;
                        operand_r <= {held_burst_sel_r, first_ca[5], ca};
                    end
                    `ENC_CAS2: begin
                        op_code_r <= held_op_r;
                        if (held_op_r == `OPC_MPC) begin
                            operand_r <= {1'b0, 1'b1, held_hi_r};
                        end else if (held_op_r == `OPC_MRR) begin
                            mode_addr_r <= held_hi_r;
                        end
                        bank_r <= held_bank_r;
                        bank_mask_r <= {{(NUM_BANKS-1){1'b0}}, 1'b1} << held_bank_r;
                        auto_precharge_flag_r <= held_autopre_r;
                        column_r <= {held_c9_r, first_ca[5], ca, 2'b00};
                        if (held_op_r == `OPC_MWR) begin
                            burst_len_r <= `BURST_SHORT;
                        end else if (otf_enable) begin
                            burst_len_r <= held_burst_sel_r ? `BURST_LONG : `BURST_SHORT;
                        end else begin
                            burst_len_r <= default_burst_long ? `BURST_LONG : `BURST_SHORT;
                        end
                    end
                    default: begin
                        // activate second half: rows 9:6 from first cycle, 5:0 second
                        op_code_r <= `OPC_ACT;
                        bank_r <= held_bank_r;
                        bank_mask_r <= {{(NUM_BANKS-1){1'b0}}, 1'b1} << held_bank_r;
                        row_r <= {held_hi_r[3:0], held_autopre_r, held_c9_r, first_ca[5:2], ca};
                    end
                endcase
            end
        end
    end
endmodule // cmd_decoder
`default_nettype wire

// ---- test/cmd_ctrl_model.sv ----
// controller-side model: turns one request into a two-cycle command on cs/ca
// assumes the bench raises req for one cycle at a time, never during a second cycle
`timescale 1ns/100ps
`default_nettype none
module cmd_ctrl_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic req,
    input wire logic [5:0] first_ca,
    input wire logic [5:0] second_ca,
    output var logic cs,
    output var logic [5:0] ca
);
    logic second_due_r;
    logic [5:0] second_hold_r;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            second_due_r <= 1'b0;
            second_hold_r <= 6'h00;
            cs <= 1'b0;
            ca <= 6'h2a;
        end else if (second_due_r) begin
            cs <= 1'b0; // second half always follows at once
            ca <= second_hold_r;
            second_due_r <= 1'b0;
        end else if (req) begin
            cs <= 1'b1; // every valid position driven to a defined level
            ca <= first_ca;
            second_hold_r <= second_ca;
            second_due_r <= 1'b1;
        end else begin
            cs <= 1'b0; // deselect: bus is don't-care, so keep it moving
            ca <= ~ca;
        end
    end
endmodule // cmd_ctrl_model
`default_nettype wire

// ---- test/cmd_decoder_sva.sv ----
// port-level checker for the command decoder
// assumes the encoding header is on the include path; bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
`include "cmd_decoder_regs.vh"
module cmd_decoder_chk #(
    parameter NUM_BANKS = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic cs,
    input wire logic [5:0] ca,
    input wire logic otf_enable,
    input wire logic reinit_done,
    input wire logic op_valid_r,
    input wire logic [3:0] op_code_r,
    input wire logic [2:0] bank_r,
    input wire logic [NUM_BANKS-1:0] bank_mask_r,
    input wire logic all_bank_select_r,
    input wire logic [5:0] burst_len_r,
    input wire logic [9:0] column_r,
    input wire logic illegal_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire bank_op = op_valid_r && (op_code_r == `OPC_PRE || op_code_r == `OPC_REF);
    wire col_op = op_valid_r && (op_code_r == `OPC_RD || op_code_r == `OPC_WR
        || op_code_r == `OPC_MWR || op_code_r == `OPC_MRR);
    wire [NUM_BANKS-1:0] one_bank = {{(NUM_BANKS-1){1'b0}}, 1'b1};

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    op_pulse_a: assert property (op_valid_r |=> !op_valid_r)
        else $error("launch pulse longer than one cycle");
    op_cause_a: assert property (op_valid_r |-> $past(cs, 2))
        else $error("launch without a selected first cycle");
    bank_onehot_a: assert property (bank_op && !all_bank_select_r |->
        bank_mask_r == (one_bank << bank_r)) else $error("bank mask not one-hot");
    all_bank_a: assert property (bank_op && all_bank_select_r |-> &bank_mask_r)
        else $error("all-bank mask incomplete");
    pre_decode_a: assert property (cs && ca[4:0] == `ENC_PRE && !illegal_r |-> ##2
        (illegal_r || (op_valid_r && op_code_r == `OPC_PRE
        && all_bank_select_r == $past(ca[5], 2)))) else $error("precharge not decoded");
    rd_burst_a: assert property (cs && ca[4:0] == `ENC_RD1 && otf_enable && !illegal_r
        |-> ##4 (illegal_r || (op_valid_r && burst_len_r ==
        ($past(ca[5], 4) ? `BURST_LONG : `BURST_SHORT)))) else $error("read burst wrong");
    col_zero_a: assert property (col_op |-> column_r[1:0] == 2'b00)
        else $error("low column bits not zero");
    mwr_short_a: assert property (op_valid_r && op_code_r == `OPC_MWR
        |-> burst_len_r == `BURST_SHORT) else $error("masked write burst not 16");
    mwr_flag_a: assert property (cs && ca[4:0] == `ENC_MWR1 && ca[5] |-> ##[1:2] illegal_r)
        else $error("masked write flag high not refused");
    illegal_mute_a: assert property (illegal_r |-> !op_valid_r)
        else $error("launch while illegal");
    illegal_hold_a: assert property (illegal_r && !reinit_done |=> illegal_r)
        else $error("illegal cleared without reinit");

    cover property (bank_op && all_bank_select_r);
    cover property (op_valid_r && op_code_r == `OPC_ACT);
    cover property ($rose(illegal_r));
endmodule // cmd_decoder_chk
`default_nettype wire

// ---- test/cmd_decoder_test.sv ----
// self-checking bench for the command decoder, stimulus through the controller model
// assumes hw/ is on the include path and the model and checker files compile first
`timescale 1ns/100ps
`default_nettype none
`include "cmd_decoder_regs.vh"
module cmd_decoder_test;
    logic clk_sys = 1'b0, rstn = 1'b0, req = 1'b0, reinit_done = 1'b0;
    logic otf_enable = 1'b1, default_burst_long = 1'b0;
    logic [5:0] f_ca = 6'h00, s_ca = 6'h00, ca, burst_len_r, mode_addr_r;
    logic cs, op_valid_r, all_bank_select_r, auto_precharge_flag_r, illegal_r;
    logic [3:0] op_code_r;
    logic [2:0] bank_r;
    logic [7:0] bank_mask_r, operand_r;
    logic [9:0] column_r;
    logic [15:0] row_r;
    int n_mismatch = 0, checked = 0, i;
    // pairs that break encoding or pairing; each must be refused
    logic [23:0] bad [6] = '{
        {1'b1, `ENC_MWR1, 6'h00, 1'b0, `ENC_CAS2, 6'h00}, // masked write flag
        {1'b0, `ENC_CAS2, 6'h00, 1'b0, `ENC_PRE, 6'h00}, // orphan second half
        {1'b0, `ENC_RD1, 6'h00, 1'b0, `ENC_PRE, 6'h00}, // read broken
        {1'b0, `ENC_MPC, 6'h15, 1'b0, `ENC_PRE, 6'h00}, // no quiet cycles
        {6'h29, 6'h13, 1'b0, `ENC_PRE, 6'h00}, // activate broken
        {1'b1, `ENC_MRW1, 6'h0d, 1'b0, `ENC_PRE, 6'h00}}; // mode write broken

    always #50 clk_sys = ~clk_sys;

    cmd_ctrl_model ctrl (.clk_sys(clk_sys), .rstn(rstn), .req(req), .first_ca(f_ca),
        .second_ca(s_ca), .cs(cs), .ca(ca));
    cmd_decoder #(.NUM_BANKS(8)) DUT (.clk_sys(clk_sys), .rstn(rstn), .cs(cs), .ca(ca),
        .otf_enable(otf_enable), .default_burst_long(default_burst_long),
        .reinit_done(reinit_done), .op_valid_r(op_valid_r), .op_code_r(op_code_r),
        .bank_r(bank_r), .bank_mask_r(bank_mask_r), .all_bank_select_r(all_bank_select_r),
        .auto_precharge_flag_r(auto_precharge_flag_r), .burst_len_r(burst_len_r),
        .column_r(column_r), .row_r(row_r), .mode_addr_r(mode_addr_r),
        .operand_r(operand_r), .illegal_r(illegal_r));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task test_done;
        if (n_mismatch == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task cmd(input logic [5:0] f, input logic [5:0] s);
        req <= 1'b1;
        f_ca <= f;
        s_ca <= s;
        @(posedge clk_sys);
        req <= 1'b0;
        @(posedge clk_sys);
    endtask

    // code 0 means no launch may appear
    task op(input logic [3:0] code);
        int k;
        logic seen;
        seen = 1'b0;
        for (k = 0; k < 4 && !seen; k++) begin
            @(posedge clk_sys);
            seen = (op_valid_r === 1'b1);
        end
        chk(seen, code != 4'h0);
        if (code != 4'h0) chk(op_code_r, code);
    endtask

    initial begin
        #1_000_000;
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        chk(burst_len_r, `BURST_SHORT); chk(op_valid_r, 0); chk(illegal_r, 0);
        for (i = 0; i < 8; i++) begin
            cmd({1'b0, `ENC_PRE}, i[5:0]); op(`OPC_PRE);
            chk(bank_mask_r, 16'h1 << i); chk(all_bank_select_r, 0);
            cmd({1'b0, `ENC_REF}, {3'b101, i[2:0]}); op(`OPC_REF); chk(bank_r, i[2:0]);
        end
        cmd({1'b1, `ENC_PRE}, 6'h05); op(`OPC_PRE); chk(bank_mask_r, 8'hff);
        chk(all_bank_select_r, 1);
        cmd({1'b1, `ENC_REF}, 6'h02); op(`OPC_REF); chk(bank_mask_r, 8'hff);
        cmd({1'b0, `ENC_SRE}, 6'h15); op(`OPC_SRE);
        cmd({1'b1, `ENC_SRX}, 6'h2a); op(`OPC_SRX);
        cmd({1'b1, `ENC_RD1}, 6'h36); cmd({1'b0, `ENC_CAS2}, 6'h2d); op(`OPC_RD);
        chk(burst_len_r, `BURST_LONG); chk(auto_precharge_flag_r, 1);
        chk(bank_r, 6); chk(column_r, 10'h2b4);
        cmd({1'b0, `ENC_WR1}, 6'h01); cmd({1'b1, `ENC_CAS2}, 6'h34); op(`OPC_WR);
        chk(burst_len_r, `BURST_SHORT); chk(auto_precharge_flag_r, 0);
        chk(column_r, 10'h1d0);
        otf_enable <= 1'b0;
        default_burst_long <= 1'b1;
        cmd({1'b0, `ENC_MWR1}, 6'h22); cmd({1'b0, `ENC_CAS2}, 6'h00); op(`OPC_MWR);
        chk(burst_len_r, `BURST_SHORT); chk(auto_precharge_flag_r, 1);
        cmd({1'b0, `ENC_RD1}, 6'h03); cmd({1'b0, `ENC_CAS2}, 6'h3f); op(`OPC_RD);
        chk(burst_len_r, `BURST_LONG);
        otf_enable <= 1'b1;
        cmd({1'b0, `ENC_MRR1}, 6'h1b); cmd({1'b0, `ENC_CAS2}, 6'h00); op(`OPC_MRR);
        chk(mode_addr_r, 6'h1b);
        cmd(6'h29, 6'h13); cmd(6'h1f, 6'h03); op(`OPC_ACT);
        chk(row_r, 16'ha5c3); chk(bank_r, 3);
        cmd({1'b1, `ENC_MRW1}, 6'h0d); cmd({1'b0, `ENC_MRW2}, 6'h2e); op(`OPC_MRW);
        chk(mode_addr_r, 6'h0d); chk(operand_r, 8'hae);
        cmd({1'b1, `ENC_MPC}, 6'h01); cmd({1'b0, `ENC_CAS2}, 6'h00); op(`OPC_MPC);
        chk(operand_r[6:0], 7'h41);
        cmd({1'b0, `ENC_MPC}, 6'h15); op(`OPC_MPC); chk(operand_r[6:0], 7'h15);
        cmd({1'b0, `ENC_PRE}, 6'h04); op(`OPC_PRE);
        for (i = 0; i < 6; i++) begin
            cmd(bad[i][23:18], bad[i][17:12]);
            cmd(bad[i][11:6], bad[i][5:0]);
            op(4'h0);
            chk(illegal_r, 1);
            reinit_done <= 1'b1;
            @(posedge clk_sys);
            reinit_done <= 1'b0;
            repeat (2) @(posedge clk_sys);
            chk(illegal_r, 0);
        end
        cmd({1'b0, `ENC_PRE}, 6'h07); op(`OPC_PRE);
        test_done();
    end
endmodule // cmd_decoder_test

bind cmd_decoder cmd_decoder_chk #(.NUM_BANKS(NUM_BANKS)) u_chk (.clk_sys(clk_sys),
    .rstn(rstn), .cs(cs), .ca(ca), .otf_enable(otf_enable), .reinit_done(reinit_done),
    .op_valid_r(op_valid_r), .op_code_r(op_code_r), .bank_r(bank_r),
    .bank_mask_r(bank_mask_r), .all_bank_select_r(all_bank_select_r),
    .burst_len_r(burst_len_r), .column_r(column_r), .illegal_r(illegal_r));
`default_nettype wire
